// file: hw/vtio_regs.sv
`include "vtio_map.svh"
module vtio_regs
  import vtio_pkg::*;
#(
  parameter int IW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          nvm_load,
  input  wire logic [3:0]    nvm_on_mant,
  input  wire logic [3:0]    nvm_off_mant,
  input  wire logic [3:0]    nvm_ofs_mant,
  input  wire logic          cmd_wr,
  input  wire logic          cmd_rd,
  input  wire logic [7:0]    cmd_code,
  input  wire logic [15:0]   cmd_wdata,
  input  wire logic          conv_enable,
  input  wire logic [7:0]    power_stage_input,
  input  wire logic [IW-1:0] iout_meas,
  input  wire logic          uv_flag_clear,
  output logic      [15:0]   cmd_rdata,
  output logic               cmd_rvalid,
  output logic               conv_run,
  output logic               input_undervoltage_flag,
  output logic      [IW-1:0] read_iout
);
  logic [3:0]  on_mant;
  logic [3:0]  off_mant;
  logic [3:0]  offset_mantissa_bits;
  logic [7:0]  on_dv;
  logic [7:0]  off_dv;
  logic [IW-1:0] iout_sum;
  logic        uv_armed;
  logic [15:0] next_rdata;
  logic        low_input;
  logic [6:0]  offset_sign_extension_bits;
  vtio_conv_t  conv_state;

  // power-input voltage in tenths of a volt
  assign low_input = enable_and_low(conv_enable, power_stage_input, off_dv);

  function automatic logic enable_and_low(input logic en, input logic [7:0] v, input logic [7:0] th);
    enable_and_low = en && (v < th);
  endfunction : enable_and_low

  // offset middle bits copy the mantissa sign, never stored
  assign offset_sign_extension_bits = {7{offset_mantissa_bits[`VTIO_MAN_MSB]}};

  // read word assembly, shared by the two threshold registers
  function automatic logic [15:0] thresh_word(input logic [3:0] m);
    thresh_word = {`VTIO_EXP_VOLT, 7'h00, m};
  endfunction : thresh_word

  vtio_thresh_map u_map (
    .mant_on  (on_mant),
    .mant_off (off_mant),
    .on_dv    (on_dv),
    .off_dv   (off_dv)
  );

  vtio_iout_cal #(.IW(IW)) u_cal (
    .iout_meas (iout_meas),
    .ofs_mant  (offset_mantissa_bits),
    .iout_sum  (iout_sum)
  );

  // mantissa storage; nvm load wins over a host write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      on_mant              <= 4'h0;
      off_mant             <= 4'h0;
      offset_mantissa_bits <= 4'h0;
    end else if (nvm_load) begin
      on_mant              <= nvm_on_mant;
      off_mant             <= nvm_off_mant;
      offset_mantissa_bits <= nvm_ofs_mant;
    end else if (cmd_wr) begin
      // upper bits of every write are discarded, read-only
      unique case (cmd_code)
        `VTIO_CMD_TURN_ON:  on_mant <= cmd_wdata[3:0];
        `VTIO_CMD_TURN_OFF: off_mant <= cmd_wdata[3:0]; // no order check against start level
        `VTIO_CMD_IOUT_OFS: offset_mantissa_bits <= cmd_wdata[3:0];
        default: ;
      endcase
    end
  end

  // read mux
  always_comb begin
    unique case (cmd_code)
      `VTIO_CMD_TURN_ON:  next_rdata = thresh_word(on_mant);
      `VTIO_CMD_TURN_OFF: next_rdata = thresh_word(off_mant);
      `VTIO_CMD_IOUT_OFS: next_rdata = {`VTIO_EXP_AMP, offset_sign_extension_bits, offset_mantissa_bits};
      default:            next_rdata = 16'h0000;
    endcase
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_rdata  <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata <= next_rdata;
      end
    end
  end

  // conversion state: start at threshold, stop below stop level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_state <= VTIO_IDLE;
      conv_run   <= 1'b0;
    end else begin
      unique case (conv_state)
        VTIO_IDLE, VTIO_STOPPED: begin
          if (conv_enable && power_stage_input >= on_dv) begin
            conv_state <= VTIO_RUNNING;
            conv_run   <= 1'b1;
          end
        end
        VTIO_RUNNING: begin
          if (!conv_enable) begin
            conv_state <= VTIO_IDLE;
            conv_run   <= 1'b0;
          end else if (low_input) begin
            conv_state <= VTIO_STOPPED;
            conv_run   <= 1'b0;
          end
        end
        default: begin
          conv_state <= VTIO_IDLE;
          conv_run   <= 1'b0;
        end
      endcase
    end
  end

  // mask re-armed only by reset, never by enable or nvm activity
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      uv_armed <= 1'b0;
    end else if (power_stage_input > on_dv) begin
      uv_armed <= 1'b1;
    end
  end

  // sticky flag; a new event wins over clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      input_undervoltage_flag <= 1'b0;
    end else if (uv_armed && low_input) begin
      input_undervoltage_flag <= 1'b1;
    end else if (uv_flag_clear) begin
      input_undervoltage_flag <= 1'b0;
    end
  end

  // reported current registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      read_iout <= '0;
    end else begin
      read_iout <= iout_sum;
    end
  end

  // checks: read port, answer one cycle after the strobe
  rd_answer_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd |=> cmd_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
    !cmd_rd |=> !cmd_rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !cmd_rd |=> $stable(cmd_rdata))
    else $error("read word moved without read");
  unk_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd && cmd_code != `VTIO_CMD_TURN_ON && cmd_code != `VTIO_CMD_TURN_OFF
      && cmd_code != `VTIO_CMD_IOUT_OFS |=> cmd_rdata == 16'h0000)
    else $error("unknown code read not zero");
  on_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd && cmd_code == `VTIO_CMD_TURN_ON |=> cmd_rdata == {`VTIO_EXP_VOLT, 7'h00, $past(on_mant)})
    else $error("start read word wrong");
  thresh_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd && cmd_code == `VTIO_CMD_TURN_OFF |=> cmd_rvalid && cmd_rdata == {12'h000, $past(off_mant)})
    else $error("threshold read word wrong");
  ofs_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd && cmd_code == `VTIO_CMD_IOUT_OFS |=> cmd_rdata[15:11] == `VTIO_EXP_AMP
      && cmd_rdata[10:4] == {7{cmd_rdata[3]}})
    else $error("offset read word wrong");
  ofs_mant_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_rd && cmd_code == `VTIO_CMD_IOUT_OFS |=> cmd_rdata[3:0] == $past(offset_mantissa_bits))
    else $error("offset mantissa read wrong");

  // checks: mantissa storage
  wr_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_wr && !nvm_load && cmd_code == `VTIO_CMD_TURN_ON |=> on_mant == $past(cmd_wdata[3:0]))
    else $error("mantissa write lost");
  off_wr_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_wr && !nvm_load && cmd_code == `VTIO_CMD_TURN_OFF |=> off_mant == $past(cmd_wdata[3:0]))
    else $error("stop mantissa write lost");
  ofs_wr_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_wr && !nvm_load && cmd_code == `VTIO_CMD_IOUT_OFS |=> offset_mantissa_bits == $past(cmd_wdata[3:0]))
    else $error("offset write lost");
  wr_other_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_wr && !nvm_load && cmd_code == `VTIO_CMD_TURN_OFF |=> on_mant == $past(on_mant))
    else $error("write disturbed another register");
  nvm_wins_a: assert property (@(posedge clk_sys) disable iff (srst)
    nvm_load |=> on_mant == $past(nvm_on_mant) && off_mant == $past(nvm_off_mant)
      && offset_mantissa_bits == $past(nvm_ofs_mant))
    else $error("nonvolatile load lost");

  // checks: threshold maps in tenths of a volt
  on_map_a: assert property (@(posedge clk_sys) disable iff (srst)
    on_mant < 4'h3 |-> on_dv == 8'h19)
    else $error("start map wrong");
  on_map_mid_a: assert property (@(posedge clk_sys) disable iff (srst)
    on_mant == 4'h3 || on_mant == 4'h4 |-> on_dv == 8'h26)
    else $error("start map middle wrong");
  on_map_step_a: assert property (@(posedge clk_sys) disable iff (srst)
    on_mant == 4'h7 |-> on_dv == 8'h46)
    else $error("start map step wrong");
  on_map_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    on_mant >= 4'ha |-> on_dv == 8'h64)
    else $error("start map top wrong");
  off_map_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    off_mant < 4'h3 |-> off_dv == 8'h17)
    else $error("stop map bottom wrong");
  off_map_mid_a: assert property (@(posedge clk_sys) disable iff (srst)
    off_mant == 4'h3 || off_mant == 4'h4 |-> off_dv == 8'h24)
    else $error("stop map middle wrong");
  off_map_a: assert property (@(posedge clk_sys) disable iff (srst)
    off_mant == 4'h5 |-> off_dv == 8'h2a)
    else $error("stop map wrong");
  off_map_step_a: assert property (@(posedge clk_sys) disable iff (srst)
    off_mant == 4'h8 |-> off_dv == 8'h4b)
    else $error("stop map step wrong");
  off_map_high_a: assert property (@(posedge clk_sys) disable iff (srst)
    off_mant >= 4'ha |-> off_dv == 8'h5f)
    else $error("stop map top wrong");

  // checks: conversion control
  conv_start_a: assert property (@(posedge clk_sys) disable iff (srst)
    !conv_run && conv_enable && power_stage_input >= on_dv |=> conv_run)
    else $error("conversion not started");
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !conv_run && power_stage_input < on_dv |=> !conv_run)
    else $error("conversion started below start level");
  conv_disable_a: assert property (@(posedge clk_sys) disable iff (srst)
    !conv_enable |=> !conv_run)
    else $error("conversion runs while disabled");
  conv_stop_a: assert property (@(posedge clk_sys) disable iff (srst)
    conv_run && conv_enable && power_stage_input < off_dv |=> !conv_run)
    else $error("conversion not stopped");
  conv_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    conv_run && conv_enable && power_stage_input >= off_dv |=> conv_run)
    else $error("conversion dropped above stop level");

  // checks: undervoltage flag and its power-on mask
  uv_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    !uv_armed && !input_undervoltage_flag |=> !input_undervoltage_flag)
    else $error("flag set while masked");
  uv_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    uv_armed && conv_enable && power_stage_input < off_dv |=> input_undervoltage_flag)
    else $error("undervoltage flag not set");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    uv_flag_clear && !(uv_armed && conv_enable && power_stage_input < off_dv)
      |=> !input_undervoltage_flag)
    else $error("flag not cleared");
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    input_undervoltage_flag && !uv_flag_clear |=> input_undervoltage_flag)
    else $error("flag dropped without clear");
  arm_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    power_stage_input > on_dv |=> uv_armed)
    else $error("mask not lifted above start level");
  arm_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    !uv_armed && power_stage_input <= on_dv |=> !uv_armed)
    else $error("mask lifted early");
  arm_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    uv_armed |=> uv_armed)
    else $error("mask re-armed without reset");

  // checks: reported current
  iout_clamp_a: assert property (@(posedge clk_sys) disable iff (srst)
    iout_meas < 16'h0008 && offset_mantissa_bits == 4'h8 |=> read_iout == 16'h0000)
    else $error("current not clamped");
  iout_add_a: assert property (@(posedge clk_sys) disable iff (srst)
    offset_mantissa_bits == 4'h7 && iout_meas < 16'h0100 |=> read_iout == $past(iout_meas) + 16'h0007)
    else $error("offset not added");
  iout_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    offset_mantissa_bits == 4'h0 |=> read_iout == $past(iout_meas))
    else $error("zero offset changed current");
  iout_sat_a: assert property (@(posedge clk_sys) disable iff (srst)
    iout_meas == {IW{1'b1}} && offset_mantissa_bits == 4'h7 |=> read_iout == {IW{1'b1}})
    else $error("full scale current wrapped");
endmodule : vtio_regs

// file: hw/vtio_map.svh
`ifndef VTIO_MAP_SVH
`define VTIO_MAP_SVH
// command codes
`define VTIO_CMD_TURN_ON      8'h35
`define VTIO_CMD_TURN_OFF     8'h36
`define VTIO_CMD_IOUT_OFS     8'h39
// field positions
`define VTIO_EXP_MSB          15
`define VTIO_EXP_LSB          11
`define VTIO_MAN_MSB          3
// fixed exponents
`define VTIO_EXP_VOLT         5'h00
`define VTIO_EXP_AMP          5'h1e
// thresholds in tenths of a volt
`define VTIO_ON_LOW           8'h19
`define VTIO_ON_MID           8'h26
`define VTIO_ON_HIGH          8'h64
`define VTIO_OFF_LOW          8'h17
`define VTIO_OFF_MID          8'h24
`define VTIO_OFF_FIVE         8'h2a
`define VTIO_OFF_HIGH         8'h5f
`endif

// file: hw/vtio_pkg.sv
package vtio_pkg;
  typedef enum logic [1:0] {
    VTIO_IDLE    = 2'b00,
    VTIO_RUNNING = 2'b01,
    VTIO_STOPPED = 2'b10
  } vtio_conv_t;
endpackage : vtio_pkg

// file: hw/vtio_thresh_map.sv
`include "vtio_map.svh"
// mantissa to threshold, tenths of a volt
module vtio_thresh_map (
  input  wire logic [3:0] mant_on,
  input  wire logic [3:0] mant_off,
  output logic      [7:0] on_dv,
  output logic      [7:0] off_dv
);
  // start threshold table
  always_comb begin
    if (mant_on < 4'h3) begin
      on_dv = `VTIO_ON_LOW;
    end else if (mant_on < 4'h5) begin
      on_dv = `VTIO_ON_MID;
    end else if (mant_on < 4'ha) begin
      on_dv = 8'(mant_on * 8'h0a);
    end else begin
      on_dv = `VTIO_ON_HIGH;
    end
  end
  // stop threshold table, half volt below whole steps for mantissas 6 to 9
  always_comb begin
    if (mant_off < 4'h3) begin
      off_dv = `VTIO_OFF_LOW;
    end else if (mant_off < 4'h5) begin
      off_dv = `VTIO_OFF_MID;
    end else if (mant_off == 4'h5) begin
      off_dv = `VTIO_OFF_FIVE;
    end else if (mant_off < 4'ha) begin
      off_dv = 8'(mant_off * 8'h0a - 8'h05);
    end else begin
      off_dv = `VTIO_OFF_HIGH;
    end
  end
endmodule : vtio_thresh_map

// file: hw/vtio_iout_cal.sv
`include "vtio_map.svh"
// adds signed quarter-amp offset, clamps at zero
module vtio_iout_cal #(
  parameter int IW = 16
) (
  input  wire logic [IW-1:0] iout_meas,
  input  wire logic [3:0]    ofs_mant,
  output logic      [IW-1:0] iout_sum
);
  logic signed [IW+1:0] sum;
  always_comb begin
    sum = $signed({2'b00, iout_meas}) + (IW+2)'($signed(ofs_mant));
    if (sum < 0) begin
      iout_sum = '0;
    end else if (sum[IW]) begin
      iout_sum = '1; // full scale saturates; wrapping would report a tiny current
    end else begin
      iout_sum = sum[IW-1:0];
    end
  end
endmodule : vtio_iout_cal

// file: testbench/vtio_host.sv
// register host on the far side: one command per call, launched at the falling edge
module vtio_host (
  input  wire logic        clk_sys,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one-cycle strobe; code and data are inverted after release so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_sys);
    cmd_wr = w;
    cmd_rd = !w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask : xfer
endmodule : vtio_host

// file: testbench/vtio_regs_tb.sv
module vtio_regs_tb;
  import vtio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, srst, nvm_load, conv_enable, uv_flag_clear;
  logic [3:0]  nvm_on_mant, nvm_off_mant, nvm_ofs_mant;
  logic        cmd_wr, cmd_rd, cmd_rvalid, conv_run, input_undervoltage_flag;
  logic [7:0]  cmd_code, power_stage_input;
  logic [15:0] cmd_wdata, cmd_rdata, iout_meas, read_iout;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'hf9d08413;
  int          err_count = 0, compares = 0, cyc = 0, s;

  vtio_regs #(.IW(16)) DUT (.clk_sys(clk_sys), .srst(srst), .nvm_load(nvm_load), .nvm_on_mant(nvm_on_mant),
    .nvm_off_mant(nvm_off_mant), .nvm_ofs_mant(nvm_ofs_mant), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .conv_enable(conv_enable), .power_stage_input(power_stage_input),
    .iout_meas(iout_meas), .uv_flag_clear(uv_flag_clear), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .conv_run(conv_run), .input_undervoltage_flag(input_undervoltage_flag), .read_iout(read_iout));
  vtio_host host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected thresholds in tenths of a volt
  function automatic logic [7:0] on_dv(input int m);
    if (m < 3) return 8'h19;
    if (m < 5) return 8'h26;
    if (m < 10) return 8'(m * 10);
    return 8'h64;
  endfunction : on_dv

  function automatic logic [7:0] off_dv(input int m);
    if (m < 3) return 8'h17;
    if (m < 5) return 8'h24;
    if (m == 5) return 8'h2a;
    if (m < 10) return 8'(m * 10 - 5);
    return 8'h5f;
  endfunction : off_dv

  task automatic chk(input logic [15:0] seen, input logic [15:0] expd);
    compares++;
    if (seen !== expd) begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, expd);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // upper write bits are random: the device must ignore them
  task automatic wr(input logic [7:0] c, input logic [3:0] m);
    host.xfer(1'b1, c, 16'(rnd() & 32'h0000fff0) | {12'h000, m});
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, c, 16'h0000);
  endtask : rd

  // read results are matched against the oldest noted expectation
  always @(negedge clk_sys) begin
    if (cmd_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'hdead, 16'hbeef);
      else chk(cmd_rdata, exp_q.pop_front());
    end
  end

  // watchdog well past the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    srst = 1'b1;
    {nvm_load, conv_enable, uv_flag_clear, power_stage_input, iout_meas} = '0;
    {nvm_on_mant, nvm_off_mant, nvm_ofs_mant} = {4'h5, 4'h3, 4'h8};
    tick(12);
    srst = 1'b0;
    chk({conv_run, input_undervoltage_flag}, 16'h0000);
    // power-on defaults, including most negative offset
    nvm_load = 1'b1;
    tick(1);
    nvm_load = 1'b0;
    rd(8'h35, 16'h0005);
    rd(8'h36, 16'h0003);
    rd(8'h39, 16'hf7f8);
    // every mantissa through every register, back to back
    for (int m = 0; m < 16; m++) begin
      wr(8'h35, 4'(m));
      wr(8'h36, 4'(m));
      wr(8'h39, 4'(m));
      rd(8'h35, 16'(m));
      rd(8'h36, 16'(m));
      rd(8'h39, {5'h1e, {7{m[3]}}, 4'(m)});
    end
    wr(8'h37, 4'ha);
    rd(8'h37, 16'h0000);
    // flag stays masked before the input has ever exceeded the start level
    conv_enable = 1'b1;
    tick(3);
    chk(input_undervoltage_flag, 16'h0000);
    wr(8'h36, 4'h0);
    for (int m = 0; m < 16; m++) begin
      conv_enable = 1'b0;
      wr(8'h35, 4'(m));
      power_stage_input = on_dv(m) - 8'h01;
      conv_enable = 1'b1;
      tick(2);
      chk(conv_run, 16'h0000);
      power_stage_input = on_dv(m);
      tick(2);
      chk(conv_run, 16'h0001);
    end
    // arm once, then a restore must not disturb the armed state
    wr(8'h35, 4'h0);
    power_stage_input = 8'h1a;
    tick(2);
    nvm_load = 1'b1;
    tick(1);
    nvm_load = 1'b0;
    wr(8'h35, 4'hf); // start kept above every stop level
    for (int m = 0; m < 16; m++) begin
      wr(8'h36, 4'(m));
      {uv_flag_clear, conv_enable} = 2'b10;
      tick(1);
      {uv_flag_clear, conv_enable} = 2'b01;
      power_stage_input = 8'h64;
      tick(2);
      chk(conv_run, 16'h0001);
      power_stage_input = off_dv(m);
      tick(2);
      chk({conv_run, input_undervoltage_flag}, 16'h0002);
      power_stage_input = off_dv(m) - 8'h01;
      tick(2);
      chk({conv_run, input_undervoltage_flag}, 16'h0001);
    end
    // only a reset brings the mask back
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    power_stage_input = 8'h00;
    tick(3);
    chk(input_undervoltage_flag, 16'h0000);
    // offset added to random current, clamped at zero
    for (int m = 0; m < 16; m++) begin
      wr(8'h39, 4'(m));
      iout_meas = 16'(rnd() & 32'h0000000f);
      s = int'(iout_meas) + int'($signed(4'(m)));
      tick(2);
      chk(read_iout, (s < 0) ? 16'h0000 : 16'(s));
    end
    tick(3);
    // full-scale current with the largest offset must saturate, not wrap
    wr(8'h39, 4'h7);
    iout_meas = 16'hffff;
    tick(2);
    chk(read_iout, 16'hffff);
    chk(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule : vtio_regs_tb
